//--- logic/shared_vector_select.sv
// one shared vector select register: enables, sticky flags, masked request
`timescale 1ns/1ps
`include "trap_vec_cfg.svh"
module shared_vector_select
    import trap_vec_pkg::*;
#(
    parameter int unsigned SOURCES = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // source events
    input wire logic [SOURCES-1:0] event_in,
    // software access
    input wire logic write,
    input wire logic [15:0] wdata,
    // state
    output logic [15:0] value,
    output logic request
);
    logic [SOURCES-1:0] enable;
    logic [SOURCES-1:0] flag;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable <= '0;
        end else if (write) begin
            enable <= wdata[`EN_LSB +: SOURCES];
        end
    end

    // writing a 0 clears a flag; a new event wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag <= '0;
        end else begin
            flag <= (write ? (flag & wdata[`FL_LSB +: SOURCES]) : flag) | event_in;
        end
    end

    always_comb begin
        value = {enable, flag};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            request <= 1'b0;
        end else begin
            request <= |(enable & flag);
        end
    end

    property p_flag_sticky;
        @(posedge hclk) disable iff (!hresetn) |event_in |=> ((flag & $past(event_in)) == $past(event_in));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("event flag lost");

    property p_mask;
        @(posedge hclk) disable iff (!hresetn) ((enable & flag) == '0) |=> !request;
    endproperty
    a_mask: assert property (p_mask) else $error("masked source raised request");
endmodule : shared_vector_select

//--- logic/trap_vectoring.sv
// interrupt and trap vectoring with AHB-Lite register access
//
// Overview of operation
// - each on-chip source has flag, enable and vector at four times trap number.
// - hardware traps react immediately, unmaskable, branching to their vector.
// - each hardware trap sets its own bit in the trap flag register.
// - hardware trap preempts everything except an equal or higher priority trap service.
// - no interrupt or event transfer interrupts a running hardware trap service.
// - four shared vectors, each with its own 16-bit select register.
// - select bits 15:8 are per-source enables.
// - select bits 7:0 are per-source flags.
// - shared vector request only from enabled and pending sources.
// - flags set and readable even when their enable is clear.
// - serial unit receive and transmit requests route to vectors 0, 1, 2.
// - errors and lock loss to vector 3; CANs and pulse unit as listed.
// - all resets vector to trap 00h with highest priority.
// - class A trap numbers 02h, 04h, 06h, second priority level.
// - all class B traps share vector 0028h, each with its own flag.
// - class B ranks below class A and resets.
// - resets and hardware traps force interrupt level to 15.
// - software trap vectors 0000h-01FCh via numbers 00h-7Fh at current priority.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "trap_vec_cfg.svh"
module trap_vectoring
    import trap_vec_pkg::*;
#(
    parameter int unsigned SHARED = 4,
    parameter int unsigned SOURCES = 8
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // reset causes
    input wire logic hw_reset_req,
    input wire logic sw_reset_req,
    input wire logic watchdog_overflow,
    // class a traps
    input wire logic nmi_trap,
    input wire logic stack_overflow_trap,
    input wire logic stack_underflow_trap,
    // class b traps
    input wire logic undefined_opcode_trap,
    input wire logic multiply_accumulate_trap,
    input wire logic protected_instruction_fault,
    input wire logic illegal_operand_access,
    input wire logic illegal_instruction_access,
    input wire logic illegal_external_bus_access,
    // extension peripheral sources
    input wire logic can1_req,
    input wire logic can2_req,
    input wire logic i2c_rx,
    input wire logic i2c_tx,
    input wire logic i2c_err,
    input wire logic ssc_rx,
    input wire logic ssc_tx,
    input wire logic ssc_err,
    input wire logic asc_rx,
    input wire logic asc_tx,
    input wire logic asc_tbuf,
    input wire logic asc_err,
    input wire logic clock_lock_loss,
    input wire logic pwm_req,
    // standard on-chip source (timer 6)
    input wire logic timer6_event,
    // cpu core
    input wire logic vector_ack,
    input wire logic trap_return,
    input wire logic [3:0] cpu_level,
    output vector_req_t vector_out,
    output logic [3:0] next_level,
    output logic trap_active
);
    logic [SHARED-1:0][SOURCES-1:0] src;
    logic [SHARED-1:0][15:0] sel_value;
    logic [SHARED-1:0] sel_write;
    logic [SHARED-1:0] shared_req;
    logic [15:0] trap_flag_register;
    logic [15:0] trap_set;
    logic timer6_flag;
    logic timer6_enable;
    logic [6:0] sw_trap_number;
    logic sw_trap_pending;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic rd_pend;
    logic [11:0] rd_addr;
    trap_class_t active_class;
    trap_class_t new_class;
    srv_state_t state;
    vector_req_t pick;

    // source routing per shared vector
    always_comb begin
        src[0] = {can1_req, i2c_rx, i2c_tx, ssc_rx, ssc_tx, asc_rx, asc_tx, asc_tbuf};
        src[1] = {can2_req, i2c_rx, i2c_tx, ssc_rx, ssc_tx, asc_rx, asc_tx, asc_tbuf};
        src[2] = {pwm_req, i2c_rx, i2c_tx, ssc_rx, ssc_tx, asc_rx, asc_tx, asc_tbuf};
        src[3] = {can1_req, can2_req, pwm_req, i2c_err, ssc_err, asc_err, clock_lock_loss, 1'b0};
    end

    genvar g;
    generate
        for (g = 0; g < SHARED; g++) begin : g_sel
            shared_vector_select #(.SOURCES(SOURCES)) u_sel (
                .hclk(hclk),
                .hresetn(hresetn),
                .event_in(src[g]),
                .write(sel_write[g]),
                .wdata(hwdata[15:0]),
                .value(sel_value[g]),
                .request(shared_req[g])
            );
            always_comb begin
                sel_write[g] = wr_pend && (wr_addr == 12'(`SEL0_OFFSET + 4 * g));
            end
        end
    endgenerate

    // ahb-lite address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= '0;
            rd_addr <= '0;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            rd_pend <= hsel && hready && htrans[1] && !hwrite;
            wr_addr <= haddr;
            rd_addr <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data is registered: a read answers one cycle after the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr)
                `SEL0_OFFSET: hrdata <= {16'h0000, sel_value[0]};
                `SEL1_OFFSET: hrdata <= {16'h0000, sel_value[1]};
                `SEL2_OFFSET: hrdata <= {16'h0000, sel_value[2]};
                `SEL3_OFFSET: hrdata <= {16'h0000, sel_value[3]};
                `TRAP_FLAG_OFFSET: hrdata <= {16'h0000, trap_flag_register};
                `STATUS_OFFSET: hrdata <= {24'h000000, timer6_enable, timer6_flag, active_class,
                                           shared_req};
                `REQ_OFFSET: hrdata <= {28'h0000000, shared_req};
                `SW_TRAP_OFFSET: hrdata <= {24'h000000, sw_trap_pending, sw_trap_number};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // standard source: timer 6 with request and enable flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer6_flag <= 1'b0;
            timer6_enable <= 1'b0;
        end else begin
            if (wr_pend && wr_addr == `STATUS_OFFSET) begin
                timer6_enable <= hwdata[7];
            end
            timer6_flag <= timer6_event
                || (timer6_flag && !(wr_pend && wr_addr == `STATUS_OFFSET && !hwdata[6])
                    && !(vector_ack && state == st_vector && pick.trap_number == `TN_T6));
        end
    end

    // software trap request register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_trap_number <= '0;
            sw_trap_pending <= 1'b0;
        end else if (wr_pend && wr_addr == `SW_TRAP_OFFSET) begin
            sw_trap_number <= hwdata[6:0];
            sw_trap_pending <= 1'b1;
        end else if (vector_ack && state == st_vector && active_class == cls_none && pick.trap_number
                     == sw_trap_number && !(|shared_req) && !(timer6_flag && timer6_enable)) begin
            sw_trap_pending <= 1'b0;
        end
    end

    // trap flag register: one bit per hardware trap, set wins over software clear
    always_comb begin
        trap_set = 16'h0000;
        trap_set[15] = nmi_trap;
        trap_set[14] = stack_overflow_trap;
        trap_set[13] = stack_underflow_trap;
        trap_set[7] = undefined_opcode_trap;
        trap_set[6] = multiply_accumulate_trap;
        trap_set[5] = protected_instruction_fault;
        trap_set[3] = illegal_operand_access;
        trap_set[2] = illegal_instruction_access;
        trap_set[1] = illegal_external_bus_access;
        trap_set[0] = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trap_flag_register <= '0;
        end else if (wr_pend && wr_addr == `TRAP_FLAG_OFFSET) begin
            trap_flag_register <= (trap_flag_register & hwdata[15:0]) | trap_set;
        end else begin
            trap_flag_register <= trap_flag_register | trap_set;
        end
    end

    // priority selection: reset, class a, class b, then interrupts and software traps
    always_comb begin
        pick = '0;
        new_class = cls_none;
        if (hw_reset_req || sw_reset_req || watchdog_overflow) begin
            pick = '{1'b1, `TN_RESET, 9'h000, 1'b1};
            new_class = cls_reset;
        end else if (nmi_trap || stack_overflow_trap || stack_underflow_trap) begin
            if (active_class != cls_reset && active_class != cls_a) begin
                new_class = cls_a;
                if (nmi_trap) begin
                    pick = '{1'b1, `TN_NMI, {`TN_NMI, 2'b00}, 1'b1};
                end else if (stack_overflow_trap) begin
                    pick = '{1'b1, `TN_STACK_OVERFLOW_TRAP, {`TN_STACK_OVERFLOW_TRAP, 2'b00}, 1'b1};
                end else begin
                    pick = '{1'b1, `TN_STACK_UNDERFLOW_TRAP, {`TN_STACK_UNDERFLOW_TRAP, 2'b00}, 1'b1};
                end
            end
        end else if (|trap_set[7:1]) begin
            if (active_class == cls_none) begin
                new_class = cls_b;
                pick = '{1'b1, `TN_CLASS_B, {`TN_CLASS_B, 2'b00}, 1'b1};
            end
        end else if (active_class == cls_none) begin
            if (|shared_req) begin
                for (int i = SHARED - 1; i >= 0; i--) begin
                    if (shared_req[i]) begin
                        pick = '{1'b1, 7'(`TN_SHARED0 + i), {7'(`TN_SHARED0 + i), 2'b00}, 1'b0};
                    end
                end
            end else if (timer6_flag && timer6_enable) begin
                pick = '{1'b1, `TN_T6, {`TN_T6, 2'b00}, 1'b0};
            end else if (sw_trap_pending) begin
                pick = '{1'b1, sw_trap_number, {sw_trap_number, 2'b00}, 1'b0};
            end
        end
    end

    // service state: hold vector until cpu acknowledges, then track trap service
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_idle;
            active_class <= cls_none;
            vector_out <= '0;
            next_level <= 4'h0;
            trap_active <= 1'b0;
        end else begin
            if (pick.valid && (state != st_vector || new_class != cls_none)) begin
                vector_out <= pick;
                state <= st_vector;
                next_level <= pick.force_level ? `LEVEL_MAX : cpu_level;
                if (new_class != cls_none) begin
                    active_class <= new_class;
                    trap_active <= 1'b1;
                end
            end else if (state == st_vector && vector_ack) begin
                vector_out.valid <= 1'b0;
                state <= (active_class != cls_none) ? st_service : st_idle;
            end else if (state == st_vector && active_class == cls_none && !pick.valid) begin
                // a level request cleared by software before it was taken, with no other request pending, is withdrawn, not taken twice
                vector_out.valid <= 1'b0;
                state <= st_idle;
            end else if (state == st_service && trap_return) begin
                state <= st_idle;
                active_class <= cls_none;
                trap_active <= 1'b0;
            end
        end
    end

    property p_hw_trap_vector;
        @(posedge hclk) disable iff (!hresetn)
            (nmi_trap && active_class == cls_none && !hw_reset_req && !sw_reset_req && !watchdog_overflow)
            |=> (vector_out.valid && vector_out.address == 9'h008 && next_level == `LEVEL_MAX);
    endproperty
    a_hw_trap_vector: assert property (p_hw_trap_vector) else $error("nmi not vectored");

    property p_trap_flag;
        @(posedge hclk) disable iff (!hresetn) stack_overflow_trap |=> trap_flag_register[14];
    endproperty
    a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set");

    property p_no_int_in_trap;
        @(posedge hclk) disable iff (!hresetn)
            (trap_active && state == st_service && !trap_return) |=> !(vector_out.valid && !vector_out.force_level);
    endproperty
    a_no_int_in_trap: assert property (p_no_int_in_trap) else $error("interrupt entered trap service");

    property p_reset_vector;
        @(posedge hclk) disable iff (!hresetn)
            watchdog_overflow |=> (vector_out.trap_number == `TN_RESET && vector_out.address == 9'h000);
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("reset not vectored to zero");

    property p_class_b;
        @(posedge hclk) disable iff (!hresetn)
            (illegal_operand_access && active_class == cls_none && !nmi_trap && !stack_overflow_trap
             && !stack_underflow_trap && !hw_reset_req && !sw_reset_req && !watchdog_overflow)
            |=> (vector_out.address == 9'h028);
    endproperty
    a_class_b: assert property (p_class_b) else $error("class b vector wrong");

    property p_addr_times4;
        @(posedge hclk) disable iff (!hresetn)
            vector_out.valid |-> (vector_out.address == {vector_out.trap_number, 2'b00});
    endproperty
    a_addr_times4: assert property (p_addr_times4) else $error("vector not four times trap number");

    property p_class_a_over_b;
        @(posedge hclk) disable iff (!hresetn)
            (active_class == cls_b && stack_underflow_trap && !hw_reset_req && !sw_reset_req
             && !watchdog_overflow && !nmi_trap && !stack_overflow_trap)
            |=> (vector_out.trap_number == `TN_STACK_UNDERFLOW_TRAP);
    endproperty
    a_class_a_over_b: assert property (p_class_a_over_b) else $error("class a did not preempt");

    property p_level;
        @(posedge hclk) disable iff (!hresetn)
            (vector_out.valid && vector_out.force_level) |-> next_level == `LEVEL_MAX;
    endproperty
    a_level: assert property (p_level) else $error("level not forced");
endmodule : trap_vectoring

//--- shared/trap_vec_cfg.svh
// register offsets, field positions, reset values and trap constants
`ifndef TRAP_VEC_CFG_SVH
`define TRAP_VEC_CFG_SVH
`define SEL0_OFFSET 12'h000
`define SEL1_OFFSET 12'h004
`define SEL2_OFFSET 12'h008
`define SEL3_OFFSET 12'h00c
`define TRAP_FLAG_OFFSET 12'h010
`define STATUS_OFFSET 12'h014
`define REQ_OFFSET 12'h018
`define SW_TRAP_OFFSET 12'h01c
`define SEL_RESET 16'h0000
`define EN_MSB 15
`define EN_LSB 8
`define FL_MSB 7
`define FL_LSB 0
`define TN_RESET 7'h00
`define TN_NMI 7'h02
`define TN_STACK_OVERFLOW_TRAP 7'h04
`define TN_STACK_UNDERFLOW_TRAP 7'h06
`define TN_CLASS_B 7'h0a
`define TN_SHARED0 7'h40
`define TN_T6 7'h26
`define LEVEL_MAX 4'hf
`endif

//--- shared/trap_vec_pkg.sv
// types shared by the trap and interrupt vectoring logic
package trap_vec_pkg;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_vector = 2'b01,
        st_service = 2'b10
    } srv_state_t;
    typedef enum logic [1:0] {
        cls_none = 2'b00,
        cls_reset = 2'b01,
        cls_a = 2'b10,
        cls_b = 2'b11
    } trap_class_t;
    typedef struct packed {
        logic valid;
        logic [6:0] trap_number;
        logic [8:0] address;
        logic force_level;
    } vector_req_t;
endpackage : trap_vec_pkg

//--- test/cpu_core_model.sv
// cpu core model: takes vectors, adopts levels and ends trap services
`timescale 1ns/1ps
module cpu_core_model
    import trap_vec_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // vectoring side
    input wire vector_req_t vector_out,
    input wire logic [3:0] next_level,
    input wire logic trap_active,
    output logic vector_ack,
    output logic trap_return,
    output logic [3:0] cpu_level,
    // pacing set by the bench
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    input wire logic [7:0] service_len
);
    logic [3:0] wait_cnt;
    logic [7:0] svc_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 4'h0;
            svc_cnt <= 8'h00;
            vector_ack <= 1'b0;
            trap_return <= 1'b0;
            cpu_level <= 4'h0;
        end else begin
            vector_ack <= 1'b0;
            trap_return <= 1'b0;
            // prompt or slow acceptance, one ack per presented vector
            if (vector_out.valid === 1'b1 && ack_en && !vector_ack) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt >= ack_delay) begin
                    vector_ack <= 1'b1;
                    wait_cnt <= 4'h0;
                    cpu_level <= next_level;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
            // keep ending the service until the block drops trap_active
            if (vector_ack || trap_active !== 1'b1) begin
                svc_cnt <= 8'h00;
            end else if (svc_cnt == service_len) begin
                trap_return <= 1'b1;
                svc_cnt <= 8'h00;
                cpu_level <= 4'h0;
            end else begin
                svc_cnt <= svc_cnt + 8'h01;
            end
        end
    end
endmodule : cpu_core_model

//--- test/testbench.sv
// self-checking bench for the interrupt and trap vectoring block
`timescale 1ns/1ps
`include "trap_vec_cfg.svh"
module testbench import trap_vec_pkg::*;;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_phase;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, e_r;
    logic [26:0] ev;
    logic vector_ack, trap_return, trap_active, ack_en;
    logic [3:0] cpu_level, next_level, ack_delay;
    logic [7:0] service_len;
    logic [15:0] en;
    logic [6:0] n;
    logic [16:0] e_v;
    vector_req_t vector_out;
    logic [16:0] vq[$];
    logic [31:0] rq[$];
    int miscompares = 0;
    int check_count = 0;
    logic [31:0] route [14] = '{32'h80000080, 32'h40008000, 32'h00404040, 32'h00202020, 32'h10000000,
        32'h00101010, 32'h00080808, 32'h08000000, 32'h00040404, 32'h00020202, 32'h00010101,
        32'h04000000, 32'h02000000, 32'h20800000};
    logic [6:0] trap_tn [12] = '{7'h00, 7'h00, 7'h00, 7'h02, 7'h04, 7'h06, 7'h0a, 7'h0a, 7'h0a, 7'h0a, 7'h0a, 7'h0a};
    logic [15:0] trap_bit [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h4000, 16'h2000, 16'h0080,
        16'h0040, 16'h0020, 16'h0008, 16'h0004, 16'h0002};

    always #10 hclk = ~hclk;
    assign hready = hreadyout;

    trap_vectoring trap_vectoring_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .hw_reset_req(ev[0]), .sw_reset_req(ev[1]),
        .watchdog_overflow(ev[2]), .nmi_trap(ev[3]), .stack_overflow_trap(ev[4]), .stack_underflow_trap(ev[5]),
        .undefined_opcode_trap(ev[6]), .multiply_accumulate_trap(ev[7]), .protected_instruction_fault(ev[8]),
        .illegal_operand_access(ev[9]), .illegal_instruction_access(ev[10]),
        .illegal_external_bus_access(ev[11]), .can1_req(ev[12]), .can2_req(ev[13]), .i2c_rx(ev[14]),
        .i2c_tx(ev[15]), .i2c_err(ev[16]), .ssc_rx(ev[17]), .ssc_tx(ev[18]), .ssc_err(ev[19]),
        .asc_rx(ev[20]), .asc_tx(ev[21]), .asc_tbuf(ev[22]), .asc_err(ev[23]), .clock_lock_loss(ev[24]),
        .pwm_req(ev[25]), .timer6_event(ev[26]), .vector_ack(vector_ack), .trap_return(trap_return),
        .cpu_level(cpu_level), .vector_out(vector_out), .next_level(next_level), .trap_active(trap_active));

    cpu_core_model cpu_core_model_i (.hclk(hclk), .hresetn(hresetn), .vector_out(vector_out),
        .next_level(next_level), .trap_active(trap_active), .vector_ack(vector_ack), .trap_return(trap_return),
        .cpu_level(cpu_level), .ack_en(ack_en), .ack_delay(ack_delay), .service_len(service_len));

    task automatic end_of_test();
        if (miscompares == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic check(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : check

    function automatic logic [16:0] vexp(input logic [6:0] t, input logic f);
        return {t, t, 2'b00, f};
    endfunction : vexp

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_phase <= !wr;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_phase <= 1'b0;
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge hclk);
        ev <= '0;
    endtask : pulse

    task automatic wait_q(input int left);
        for (int i = 0; i < 400 && vq.size() > left; i++) @(posedge hclk);
        check(vq.size() <= left, "vector missing");
    endtask : wait_q

    task automatic idle();
        for (int i = 0; i < 600 && trap_active !== 1'b0; i++) @(posedge hclk);
        check(trap_active === 1'b0, "trap service stuck");
    endtask : idle

    // service done: hold the core off while the source is cleared
    task automatic clear(input logic [11:0] a, input logic [31:0] d);
        wait_q(0);
        ack_en <= 1'b0;
        bus(1'b1, a, d);
        repeat (3) @(posedge hclk);
        ack_en <= 1'b1;
    endtask : clear

    // results are matched oldest first; an unexpected vector finds an empty queue
    always @(posedge hclk) begin
        if (rd_phase && hready === 1'b1) begin
            e_r = rq.size() ? rq.pop_front() : 'x;
            check(hrdata === e_r, "read data");
            check(hresp === 1'b0, "response not okay");
        end
        if (vector_ack === 1'b1 && vector_out.valid === 1'b1) begin
            e_v = vq.size() ? vq.pop_front() : 'x;
            check({vector_out.trap_number, vector_out.address, vector_out.force_level} === e_v, "vector");
            if (e_v[0] === 1'b1) check(next_level === 4'hf, "forced level");
        end
        if (trap_active === 1'b1 && vector_out.valid === 1'b1 && vector_out.force_level === 1'b0)
            check(1'b0, "interrupt during trap service");
    end

    initial begin
        repeat (40000) @(posedge hclk);
        miscompares++;
        end_of_test();
    end

    initial begin
        {hresetn, hsel, hwrite, rd_phase, haddr, htrans, hwdata, ev} = '0;
        hsize = 3'h2;
        ack_en = 1'b1;
        ack_delay = 4'h0;
        service_len = 8'd20;
        void'($urandom(18));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a < 8; a++) rd(12'(a * 4), 32'h0);
        rd(12'h0fc, 32'h0);
        for (int s = 0; s < 14; s++) begin
            pulse(12 + s);
            repeat (2) @(posedge hclk);
            for (int v = 0; v < 4; v++) rd(12'(v * 4), {24'h0, route[s][v*8 +: 8]});
            for (int v = 0; v < 4; v++) bus(1'b1, 12'(v * 4), 32'h0);
        end
        for (int v = 0; v < 4; v++) begin
            en = (v == 3) ? 16'h1000 : 16'h8000;
            bus(1'b1, 12'(v * 4), {16'($urandom), en});
            rd(12'(v * 4), {16'h0, en});
            ack_delay <= 4'($urandom % 8);
            vq.push_back(vexp(7'(64 + v), 1'b0));
            pulse((v == 0) ? 12 : (v == 1) ? 13 : (v == 2) ? 25 : 16);
            clear(12'(v * 4), 32'h0);
        end
        for (int t = 0; t < 12; t++) begin
            vq.push_back(vexp(trap_tn[t], 1'b1));
            pulse(t);
            wait_q(0);
            idle();
            rd(`TRAP_FLAG_OFFSET, {16'h0, trap_bit[t]});
            bus(1'b1, `TRAP_FLAG_OFFSET, 32'h0);
        end
        service_len <= 8'd60;
        vq.push_back(vexp(7'h0a, 1'b1));
        vq.push_back(vexp(7'h06, 1'b1));
        vq.push_back(vexp(7'h00, 1'b1));
        pulse(6);
        wait_q(2);
        pulse(5);
        wait_q(1);
        rd(`TRAP_FLAG_OFFSET, 32'h2080);
        pulse(0);
        wait_q(0);
        idle();
        bus(1'b1, `TRAP_FLAG_OFFSET, 32'h0);
        bus(1'b1, 12'h000, 32'h8000);
        vq.push_back(vexp(7'h02, 1'b1));
        vq.push_back(vexp(7'h40, 1'b0));
        pulse(3);
        wait_q(1);
        pulse(12);
        clear(12'h000, 32'h0);
        service_len <= 8'd20;
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 7'h00 : (k == 1) ? 7'h7f : 7'($urandom % 128);
            vq.push_back(vexp(n, 1'b0));
            bus(1'b1, `SW_TRAP_OFFSET, {25'h0, n});
            wait_q(0);
        end
        bus(1'b1, `STATUS_OFFSET, 32'h80);
        vq.push_back(vexp(7'h26, 1'b0));
        pulse(26);
        clear(`STATUS_OFFSET, 32'h0);
        end_of_test();
    end
endmodule : testbench
